// ### pkg/flow_disp_pkg.sv
// Package: register map, field codes and timing for the flow display and input control block
package flow_disp_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_SCREEN  = 8'h00;
	localparam logic [7:0] ADDR_ACTION  = 8'h04;
	localparam logic [7:0] ADDR_BATCH   = 8'h08;
	localparam logic [7:0] ADDR_SERIAL  = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;

	// ---------------------------------------------------------------
	// Field layout and reset values
	// ---------------------------------------------------------------
	localparam int         SCREEN_W       = 5;
	localparam logic [4:0] SCREEN_RESET   = 5'h01;
	localparam logic [4:0] SCREEN_MAX     = 5'h12;
	localparam int         ACT_W          = 3;
	localparam int         KEY_ACT_LSB    = 0;
	localparam int         DIN_ACT_LSB    = 4;
	localparam int         BAUD_LSB       = 0;
	localparam int         BAUD_W         = 3;
	localparam int         PARITY_LSB     = 4;
	localparam int         PARITY_W       = 2;
	localparam int         ADDR_LSB       = 8;
	localparam int         STN_W          = 8;
	localparam logic [2:0] BAUD_RESET     = 3'h0;
	localparam logic [1:0] PARITY_RESET   = 2'h0;
	localparam logic [7:0] STATION_RESET  = 8'h01;
	localparam int         BATCH_CLR_BIT  = 0;
	localparam int         TOT_CLR_BIT    = 1;
	localparam logic [4:0] FEEDER_FIRST   = 5'h0D;

	// ---------------------------------------------------------------
	// Display codes
	// ---------------------------------------------------------------
	localparam int         DIGITS         = 6;
	localparam logic [3:0] DIGIT_DASH     = 4'hA;
	localparam logic [3:0] DIGIT_HIGH     = 4'hB;
	localparam logic [3:0] DIGIT_BLANK    = 4'hF;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ        = 250;
	localparam int HALF_SWAP_S    = 5;
	localparam int ALT_SCREEN_S   = 5;
	localparam int DEBOUNCE_US    = 10000;
	localparam longint HALF_SWAP_CYC  = longint'(HALF_SWAP_S) * 1000000 * CLK_MHZ;
	localparam longint ALT_SCREEN_CYC = longint'(ALT_SCREEN_S) * 1000000 * CLK_MHZ;
	localparam longint DEBOUNCE_CYC   = longint'(DEBOUNCE_US) * CLK_MHZ;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ACT_NONE    = 3'b000,
		ACT_TOT_CLR = 3'b001,
		ACT_FREEZE  = 3'b010,
		ACT_MINMAX  = 3'b011,
		ACT_FEEDER  = 3'b100,
		ACT_SUSPEND = 3'b101
	} action_t;

	typedef enum logic [3:0] {
		SRC_FLOW   = 4'h0,
		SRC_TOTAL  = 4'h1,
		SRC_NRTOT  = 4'h2,
		SRC_UNIT   = 4'h3,
		SRC_AUX    = 4'h4,
		SRC_FD_UP  = 4'h5,
		SRC_FD_DN  = 4'h6,
		SRC_FD_SP  = 4'h7
	} source_t;

	typedef struct packed {
		logic [23:0] flow;
		logic [43:0] total;
		logic [43:0] nrtotal;
		logic [23:0] unit;
		logic [23:0] aux;
		logic [23:0] feed_up;
		logic [23:0] feed_dn;
		logic [23:0] feed_sp;
	} values_t;

	typedef struct packed {
		logic [23:0] upper;
		logic [23:0] lower;
	} display_t;

	typedef struct packed {
		logic total_clear;
		logic minmax_clear;
		logic feeder_start;
		logic freeze;
		logic suspend;
	} actions_t;

endpackage : flow_disp_pkg

// ### rtl/flow_disp_ctrl.sv
// Display selection and key / digital-input action control, with APB registers
//
// Contract
// - Screens 1 to 4 pair flow with a total in either order, and 5 to 7 show one value over the unit.
// - Screen 8 alternates between screens 5 and 6, and screen 9 between 5 and 7.
// - Screens 10 to 12 show the auxiliary reading below flow, total or non-resettable total.
// - Screens 13 to 18 show feeder flow up or down with the setpoint, flow or total.
// - A total wider than six digits alternates every five seconds between its low six and H plus its high five.
// - A feeder screen with no feeder alarm configured shows dashes instead of feeder values.
// - Key and digital input each have their own action among none, total clear, freeze, min/max clear, feeder start, suspend.
// - Freeze holds the displayed values while the input is active or the key is held.
// - Min/max clear resets the stored minimum and maximum flow when activated.
// - Feeder action starts a feeder batch when activated.
// - Suspend stops totalizing and ignores the flow input while active, retransmission unaffected.
// - With batch clear off, feeder state survives a power loss and feeding resumes.
// - With batch clear on, feeder state is cleared after power loss and waits for a new start.
// - Baud rate, parity and station address are held for the serial interface.
`timescale 1ns/1ps
module flow_disp_ctrl
	import flow_disp_pkg::*;
#(
	parameter longint SWAP_CYCLES     = HALF_SWAP_CYC,
	parameter longint ALT_CYCLES      = ALT_SCREEN_CYC,
	parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        key_i,
	input  wire logic        din_i,
	input  wire values_t     values_i,
	input  wire logic        feeder_alarm_i,
	input  wire logic        power_restored_i,
	output display_t         display_o,
	output actions_t         actions_o,
	output logic             feeder_clear_o,
	output logic [2:0]       serial_baud_o,
	output logic [1:0]       serial_parity_o,
	output logic [7:0]       serial_station_o
);

	if (SWAP_CYCLES < 1 || ALT_CYCLES < 1 || DEBOUNCE_CYCLES < 1 ||
	    SWAP_CYCLES > 64'hFFFFFFFF || ALT_CYCLES > 64'hFFFFFFFF ||
	    DEBOUNCE_CYCLES > 64'hFFFFFFFF) begin : g_bad_timing
		$error("flow_disp_ctrl: timing parameter out of range");
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [SCREEN_W-1:0] main_screen_select;
	action_t             key_action;
	action_t             din_action;
	logic                batch_power_loss_clear;
	logic [BAUD_W-1:0]   baud;
	logic [PARITY_W-1:0] serial_parity_setting;
	logic [STN_W-1:0]    station;
	logic                totalizer_clear_entry;
	logic                wr_en;
	logic                rd_en;
	logic                addr_ok;

	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_en    = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign addr_ok  = (paddr_i == ADDR_SCREEN) || (paddr_i == ADDR_ACTION) ||
	                  (paddr_i == ADDR_BATCH)  || (paddr_i == ADDR_SERIAL) ||
	                  (paddr_i == ADDR_STATUS);
	assign pslverr_o = psel_i & penable_i & ~addr_ok;

	function automatic action_t to_action(input logic [ACT_W-1:0] v);
		to_action = (v > ACT_SUSPEND) ? ACT_NONE : action_t'(v);
	endfunction : to_action

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			main_screen_select <= SCREEN_RESET;
		end else if (wr_en && paddr_i == ADDR_SCREEN) begin
			if (pwdata_i[SCREEN_W-1:0] != '0 && pwdata_i[SCREEN_W-1:0] <= SCREEN_MAX) begin
				main_screen_select <= pwdata_i[SCREEN_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			key_action <= ACT_NONE;
			din_action <= ACT_NONE;
		end else if (wr_en && paddr_i == ADDR_ACTION) begin
			key_action <= to_action(pwdata_i[KEY_ACT_LSB +: ACT_W]);
			din_action <= to_action(pwdata_i[DIN_ACT_LSB +: ACT_W]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			batch_power_loss_clear <= 1'b0;
			totalizer_clear_entry  <= 1'b0;
		end else begin
			totalizer_clear_entry <= wr_en && paddr_i == ADDR_BATCH && pwdata_i[TOT_CLR_BIT];
			if (wr_en && paddr_i == ADDR_BATCH) begin
				batch_power_loss_clear <= pwdata_i[BATCH_CLR_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			baud                  <= BAUD_RESET;
			serial_parity_setting <= PARITY_RESET;
			station               <= STATION_RESET;
		end else if (wr_en && paddr_i == ADDR_SERIAL) begin
			baud                  <= pwdata_i[BAUD_LSB +: BAUD_W];
			serial_parity_setting <= pwdata_i[PARITY_LSB +: PARITY_W];
			station               <= pwdata_i[ADDR_LSB +: STN_W];
		end
	end

	assign serial_baud_o    = baud;
	assign serial_parity_o  = serial_parity_setting;
	assign serial_station_o = station;

	// ---------------------------------------------------------------
	// Synchronise and debounce key and digital input
	// ---------------------------------------------------------------
	logic [1:0]  sync_a;
	logic [1:0]  sync_b;
	logic [1:0]  level;
	logic [1:0]  level_q;
	logic [31:0] deb_cnt [2];
	logic [1:0]  raw;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sync_a <= 2'b00;
			sync_b <= 2'b00;
		end else begin
			sync_a <= {din_i, key_i};
			sync_b <= sync_a;
		end
	end
	assign raw = sync_b;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_deb
			always_ff @(posedge clk_i) begin
				if (!resetn_i) begin
					deb_cnt[i] <= '0;
					level[i]   <= 1'b0;
				end else if (raw[i] == level[i]) begin
					deb_cnt[i] <= '0;
				end else if (deb_cnt[i] >= 32'(DEBOUNCE_CYCLES - 1)) begin
					deb_cnt[i] <= '0;
					level[i]   <= raw[i];
				end else begin
					deb_cnt[i] <= deb_cnt[i] + 32'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			level_q <= 2'b00;
		end else begin
			level_q <= level;
		end
	end

	// ---------------------------------------------------------------
	// Action decode
	// ---------------------------------------------------------------
	logic [1:0] rise;
	actions_t   next_actions;
	assign rise = level & ~level_q;

	always_comb begin
		next_actions = '0;
		next_actions.total_clear  = totalizer_clear_entry |
			(rise[0] && key_action == ACT_TOT_CLR) | (rise[1] && din_action == ACT_TOT_CLR);
		next_actions.minmax_clear = (rise[0] && key_action == ACT_MINMAX) |
			(rise[1] && din_action == ACT_MINMAX);
		next_actions.feeder_start = (rise[0] && key_action == ACT_FEEDER) |
			(rise[1] && din_action == ACT_FEEDER);
		next_actions.freeze  = (level[0] && key_action == ACT_FREEZE) |
			(level[1] && din_action == ACT_FREEZE);
		next_actions.suspend = (level[0] && key_action == ACT_SUSPEND) |
			(level[1] && din_action == ACT_SUSPEND);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			actions_o <= '0;
		end else begin
			actions_o <= next_actions;
		end
	end

	// ---------------------------------------------------------------
	// Feeder power-loss retention
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			feeder_clear_o <= 1'b0;
		end else begin
			feeder_clear_o <= power_restored_i & batch_power_loss_clear;
		end
	end

	// ---------------------------------------------------------------
	// Alternation timers
	// ---------------------------------------------------------------
	logic [31:0] swap_cnt;
	logic [31:0] alt_cnt;
	logic        show_high;
	logic        alt_phase;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			swap_cnt  <= '0;
			show_high <= 1'b0;
		end else if (swap_cnt >= 32'(SWAP_CYCLES - 1)) begin
			swap_cnt  <= '0;
			show_high <= ~show_high;
		end else begin
			swap_cnt <= swap_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			alt_cnt   <= '0;
			alt_phase <= 1'b0;
		end else if (alt_cnt >= 32'(ALT_CYCLES - 1)) begin
			alt_cnt   <= '0;
			alt_phase <= ~alt_phase;
		end else begin
			alt_cnt <= alt_cnt + 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// Screen routing
	// ---------------------------------------------------------------
	source_t up_src;
	source_t lo_src;
	logic    feeder_screen;

	always_comb begin
		up_src = SRC_FLOW;
		lo_src = SRC_TOTAL;
		case (main_screen_select)
			5'd1:  begin up_src = SRC_FLOW;  lo_src = SRC_TOTAL; end
			5'd2:  begin up_src = SRC_TOTAL; lo_src = SRC_FLOW;  end
			5'd3:  begin up_src = SRC_FLOW;  lo_src = SRC_NRTOT; end
			5'd4:  begin up_src = SRC_NRTOT; lo_src = SRC_FLOW;  end
			5'd5:  begin up_src = SRC_FLOW;  lo_src = SRC_UNIT;  end
			5'd6:  begin up_src = SRC_TOTAL; lo_src = SRC_UNIT;  end
			5'd7:  begin up_src = SRC_NRTOT; lo_src = SRC_UNIT;  end
			5'd8:  begin
				up_src = alt_phase ? SRC_TOTAL : SRC_FLOW;
				lo_src = SRC_UNIT;
			end
			5'd9:  begin
				up_src = alt_phase ? SRC_NRTOT : SRC_FLOW;
				lo_src = SRC_UNIT;
			end
			5'd10: begin up_src = SRC_FLOW;  lo_src = SRC_AUX;   end
			5'd11: begin up_src = SRC_TOTAL; lo_src = SRC_AUX;   end
			5'd12: begin up_src = SRC_NRTOT; lo_src = SRC_AUX;   end
			5'd13: begin up_src = SRC_FD_UP; lo_src = SRC_FD_SP; end
			5'd14: begin up_src = SRC_FD_DN; lo_src = SRC_FD_SP; end
			5'd15: begin up_src = SRC_FLOW;  lo_src = SRC_FD_UP; end
			5'd16: begin up_src = SRC_FLOW;  lo_src = SRC_FD_DN; end
			5'd17: begin up_src = SRC_TOTAL; lo_src = SRC_FD_UP; end
			5'd18: begin up_src = SRC_TOTAL; lo_src = SRC_FD_DN; end
			default: begin up_src = SRC_FLOW; lo_src = SRC_TOTAL; end
		endcase
	end

	assign feeder_screen = (main_screen_select >= FEEDER_FIRST) &&
	                       (main_screen_select <= SCREEN_MAX);

	function automatic logic [23:0] split_total(input logic [43:0] t, input logic hi);
		logic fits;
		fits = (t[43:24] == '0);
		if (fits || !hi) begin
			split_total = t[23:0];
		end else begin
			split_total = {DIGIT_HIGH, t[43:24]};
		end
	endfunction : split_total

	function automatic logic [23:0] pick(input source_t s, input values_t v,
	                                     input logic hi, input logic fd_ok);
		logic [23:0] dash;
		dash = {DIGITS{DIGIT_DASH}};
		case (s)
			SRC_FLOW:  pick = v.flow;
			SRC_TOTAL: pick = split_total(v.total, hi);
			SRC_NRTOT: pick = split_total(v.nrtotal, hi);
			SRC_UNIT:  pick = v.unit;
			SRC_AUX:   pick = v.aux;
			SRC_FD_UP: pick = fd_ok ? v.feed_up : dash;
			SRC_FD_DN: pick = fd_ok ? v.feed_dn : dash;
			SRC_FD_SP: pick = fd_ok ? v.feed_sp : dash;
			default:   pick = {DIGITS{DIGIT_BLANK}};
		endcase
	endfunction : pick

	display_t next_display;
	always_comb begin
		next_display.upper = pick(up_src, values_i, show_high, feeder_alarm_i || !feeder_screen);
		next_display.lower = pick(lo_src, values_i, show_high, feeder_alarm_i || !feeder_screen);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			display_o <= '0;
		end else if (!next_actions.freeze) begin
			display_o <= next_display;
		end
	end

	// ---------------------------------------------------------------
	// APB read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				ADDR_SCREEN: prdata_o <= 32'(main_screen_select);
				ADDR_ACTION: prdata_o <= 32'({din_action, 1'b0, key_action});
				ADDR_BATCH:  prdata_o <= 32'(batch_power_loss_clear);
				ADDR_SERIAL: prdata_o <= 32'({station, 2'b00, serial_parity_setting, 1'b0, baud});
				ADDR_STATUS: prdata_o <= 32'({alt_phase, show_high, level,
				                               actions_o.suspend, actions_o.freeze});
				default:     prdata_o <= '0;
			endcase
		end
	end

endmodule : flow_disp_ctrl

// ### tb/flow_disp_ctrl_assertions.sv
// Checker: port-level properties of the flow display and input control block
`timescale 1ns/1ps
module flow_disp_ctrl_assertions
	import flow_disp_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire values_t     values_i,
	input wire logic        feeder_alarm_i,
	input wire logic        power_restored_i,
	input wire display_t    display_o,
	input wire actions_t    actions_o,
	input wire logic        feeder_clear_o,
	input wire logic [2:0]  serial_baud_o,
	input wire logic [1:0]  serial_parity_o,
	input wire logic [7:0]  serial_station_o
);
	// ----
	// Screen selection tracked from bus writes
	// ----
	logic [4:0] scr;
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scr <= SCREEN_RESET;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == ADDR_SCREEN
			&& pwdata_i[4:0] != 5'h00 && pwdata_i[4:0] <= SCREEN_MAX) begin
			scr <= pwdata_i[4:0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_acc;
		psel_i && penable_i;
	endsequence
	sequence s_live;
		$past(resetn_i) && !actions_o.freeze && !$past(actions_o.freeze);
	endsequence
	a_apb_ready: assert property (s_acc |-> pready_o)
		else $error("access not answered at once");
	a_unmapped_err: assert property (s_acc ##0 paddr_i > ADDR_STATUS |-> pslverr_o)
		else $error("unmapped access without error");
	a_serial_write: assert property (s_acc ##0 pwrite_i && paddr_i == ADDR_SERIAL |=>
		{serial_station_o, serial_parity_o, serial_baud_o}
		== $past({pwdata_i[15:8], pwdata_i[5:4], pwdata_i[2:0]}))
		else $error("serial settings not taken");
	a_clear_once: assert property ($rose(actions_o.total_clear) |=> !actions_o.total_clear)
		else $error("total clear longer than one cycle");
	a_minmax_once: assert property ($rose(actions_o.minmax_clear) |=> !actions_o.minmax_clear)
		else $error("min max clear longer than one cycle");
	a_start_once: assert property ($rose(actions_o.feeder_start) |=> !actions_o.feeder_start)
		else $error("feeder start longer than one cycle");
	a_freeze_hold: assert property (actions_o.freeze ##1 actions_o.freeze |-> $stable(display_o))
		else $error("display changed while frozen");
	a_power_cause: assert property (feeder_clear_o |-> $past(power_restored_i))
		else $error("feeder clear without power return");
	a_screen_one: assert property (s_live ##0 $past(scr) == 5'h01
		&& $past(values_i.total[43:24]) == 20'h0
		|-> display_o == {$past(values_i.flow), $past(values_i.total[23:0])})
		else $error("screen one routing wrong");
	a_feeder_dash: assert property (s_live ##0 $past(scr) == 5'h0F && !$past(feeder_alarm_i)
		|-> display_o.lower == {6{DIGIT_DASH}})
		else $error("feeder value shown without feeder alarm");
endmodule : flow_disp_ctrl_assertions

bind flow_disp_ctrl flow_disp_ctrl_assertions i_chk (
	.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .values_i(values_i), .feeder_alarm_i(feeder_alarm_i),
	.power_restored_i(power_restored_i), .display_o(display_o), .actions_o(actions_o),
	.feeder_clear_o(feeder_clear_o), .serial_baud_o(serial_baud_o),
	.serial_parity_o(serial_parity_o), .serial_station_o(serial_station_o));

// ### tb/panel_model.sv
// Partner: operator front key and external digital input
`timescale 1ns/1ps
module panel_model (
	input  wire logic clk_i,
	output logic      key_o = 1'h0,
	output logic      din_o = 1'h0
);
	// ----
	// Level change on one line after a clock edge
	// ----
	task automatic drive(input int which, input logic lvl);
		@(posedge clk_i);
		if (which == 1) din_o <= lvl;
		else key_o <= lvl;
	endtask : drive
	// ----
	// Press with contact bounce, hold, release
	// ----
	task automatic hold(input int which, input int cyc);
		drive(which, 1'h1);
		drive(which, 1'h0);
		drive(which, 1'h1);
		repeat (cyc) @(posedge clk_i);
		drive(which, 1'h0);
	endtask : hold
endmodule : panel_model

// ### tb/tb.sv
// Testbench: display routing, key and input actions, power-loss clear, serial settings
`timescale 1ns/1ps
module tb;
	import flow_disp_pkg::*;
	localparam int SW = 20;
	localparam int DB = 4;
	localparam logic [7:0] SCREEN_MAP [19] = '{8'h00, 8'h01, 8'h10, 8'h02, 8'h20, 8'h03,
		8'h13, 8'h23, 8'h00, 8'h00, 8'h04, 8'h14, 8'h24, 8'h57, 8'h67, 8'h05, 8'h06, 8'h15, 8'h16};
	logic        clk_i = 1'h0;
	logic        resetn_i = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        key;
	logic        din;
	logic        alarm = 1'h1;
	logic        pwr = 1'h0;
	logic        fclr;
	logic [2:0]  baud;
	logic [1:0]  par;
	logic [7:0]  stn;
	values_t     vals = '0;
	display_t    disp;
	actions_t    acts;
	int          mismatches = 0;
	int          checks = 0;
	int          seed = 89573;
	int          cur = 1;
	int          cnt[6];

	initial forever #2 clk_i = ~clk_i;

	flow_disp_ctrl #(.SWAP_CYCLES(SW), .ALT_CYCLES(SW), .DEBOUNCE_CYCLES(DB)) i_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .key_i(key), .din_i(din), .values_i(vals),
		.feeder_alarm_i(alarm), .power_restored_i(pwr), .display_o(disp), .actions_o(acts),
		.feeder_clear_o(fclr), .serial_baud_o(baud), .serial_parity_o(par),
		.serial_station_o(stn));
	panel_model i_panel (.clk_i(clk_i), .key_o(key), .din_o(din));

	// ----
	// Action and power-clear activity counters
	// ----
	always @(posedge clk_i) begin
		for (int i = 0; i < 5; i++) cnt[i] += int'(acts[4 - i] === 1'h1);
		cnt[5] += int'(fclr === 1'h1);
	end

	// ----
	// Shared tasks and display model
	// ----
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rand_vals(input logic [19:0] hi);
		logic [255:0] r;
		values_t nv;
		for (int i = 0; i < 8; i++) r[i * 32 +: 32] = $random(seed);
		nv = r[231:0];
		nv.total[43:24] = hi;
		nv.nrtotal[43:24] = 20'h0;
		@(posedge clk_i);
		vals <= nv;
	endtask : rand_vals
	function automatic display_t model(input int s);
		logic [23:0] dash;
		logic [7:0][23:0] v;
		dash = {6{DIGIT_DASH}};
		v = {alarm ? vals.feed_sp : dash, alarm ? vals.feed_dn : dash, alarm ? vals.feed_up : dash,
			vals.aux, vals.unit, vals.nrtotal[23:0], vals.total[23:0], vals.flow};
		return {v[SCREEN_MAP[s][6:4]], v[SCREEN_MAP[s][2:0]]};
	endfunction : model
	task automatic show(input int s);
		cur = s;
		apb(1'h1, ADDR_SCREEN, 32'(s));
		rand_vals(20'h0);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("display", disp, model(s));
	endtask : show
	task automatic both(input display_t a, input display_t b);
		logic sa;
		logic sb;
		sa = 1'h0;
		sb = 1'h0;
		repeat (3 * SW) begin
			@(negedge clk_i);
			sa |= disp === a;
			sb |= disp === b;
		end
		chk("alternation", {sa, sb}, 2'h3);
	endtask : both
	task automatic act(input int src, input int code, input int len);
		display_t snap;
		logic lng;
		lng = len > DB;
		apb(1'h1, ADDR_ACTION, 32'(code) << (src == 1 ? DIN_ACT_LSB : KEY_ACT_LSB));
		cnt = '{default: 0};
		fork
			i_panel.hold(src, len);
		join_none
		repeat (DB + 8) @(posedge clk_i);
		@(negedge clk_i);
		snap = disp;
		rand_vals(20'h0);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		if (code == 2 && lng) chk("frozen display", disp, snap);
		repeat (len + DB + 8) @(posedge clk_i);
		@(negedge clk_i);
		chk("display released", disp, model(cur));
		chk("actions", {cnt[0] == 1, cnt[1] == 1, cnt[2] == 1, cnt[3] > 0, cnt[4] > 0,
			acts.freeze | acts.suspend}, {code == 1 && lng, code == 3 && lng,
			code == 4 && lng, code == 2 && lng, code == 5 && lng, 1'h0});
	endtask : act
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// ----
	// Main sequence
	// ----
	initial begin
		logic [31:0] w;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'h1;
		apb(1'h0, ADDR_SCREEN, 32'h0);
		chk("screen reset", rd, 32'(SCREEN_RESET));
		apb(1'h0, ADDR_SERIAL, 32'h0);
		chk("serial reset", rd, {16'h0, STATION_RESET, 2'h0, PARITY_RESET, 1'h0, BAUD_RESET});
		apb(1'h0, 8'h20, 32'h0);
		chk("unmapped", {err, rd}, {1'h1, 32'h0});
		apb(1'h1, ADDR_SCREEN, 32'h0);
		apb(1'h1, ADDR_SCREEN, 32'h13);
		apb(1'h0, ADDR_SCREEN, 32'h0);
		chk("screen refused", rd, 32'h1);
		for (int a = 1; a >= 0; a--) begin
			@(posedge clk_i);
			alarm <= a[0];
			for (int s = 1; s <= 18; s++) if (s != 8 && s != 9) show(s);
		end
		apb(1'h1, ADDR_SCREEN, 32'h8);
		both({vals.flow, vals.unit}, {vals.total[23:0], vals.unit});
		apb(1'h1, ADDR_SCREEN, 32'h9);
		both({vals.flow, vals.unit}, {vals.nrtotal[23:0], vals.unit});
		rand_vals(20'h2A5C3);
		apb(1'h1, ADDR_SCREEN, 32'h1);
		both({vals.flow, vals.total[23:0]}, {vals.flow, DIGIT_HIGH, vals.total[43:24]});
		show(18);
		for (int src = 0; src < 2; src++) for (int c = 0; c < 7; c++) act(src, c, DB + 12);
		act(0, 1, 1);
		for (int b = 0; b < 2; b++) begin
			apb(1'h1, ADDR_BATCH, 32'(b) | (32'h1 << TOT_CLR_BIT));
			cnt = '{default: 0};
			@(posedge clk_i);
			pwr <= 1'h1;
			@(posedge clk_i);
			pwr <= 1'h0;
			repeat (4) @(negedge clk_i);
			chk("feeder clear pulses", cnt[5], b);
			chk("clear entry pulses", cnt[0], 1);
		end
		w = $random(seed) & 32'h0000FF37;
		apb(1'h1, ADDR_SERIAL, w);
		@(negedge clk_i);
		chk("serial ports", {stn, par, baud}, {w[15:8], w[5:4], w[2:0]});
		apb(1'h0, ADDR_SERIAL, 32'h0);
		chk("serial readback", rd, w);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("status idle", {err, rd[3:0]}, 5'h00);
		conclude();
	end

	initial begin
		repeat (30000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
endmodule : tb
